// file: design/ucsa_top.sv
`timescale 1ns/10ps
module ucsa_top import ucsa_pkg::*; #(
   parameter int WC_CYCLES = WC_CYC,
   parameter logic [6:0] QTR_LAST = QTR_M1
) (
   // clock and reset
   input logic ref_clk_in,
   input logic resetn_in,
   // control request
   input logic setup_valid_in,
   input ucsa_setup_s setup_in,
   output logic setup_ready_out,
   output logic req_err_out,
   output logic done_out,
   // data stage
   input logic wr_valid_in,
   input logic [7:0] wr_data_in,
   output logic wr_ready_out,
   output logic rd_valid_out,
   output logic [7:0] rd_data_out,
   input logic rd_ready_in,
   // configuration image
   output ucsa_cfg_t cfg_out,
   output ucsa_name_t name_out,
   output logic boot_done_out,
   // serial memory
   output logic scl_out,
   input logic sda_in,
   output logic sda_out,
   output logic sda_oe_out
);
   function automatic ucsa_op_e step_op(input logic rd, input logic [2:0] s);
      if (s == 3'h0 || (rd && s == 3'h3)) begin
         return OP_START;
      end
      if (s == (rd ? STEP_RD_LAST : STEP_WR_LAST)) begin
         return OP_STOP;
      end
      return (rd && s == 3'h5) ? OP_RD : OP_WR;
   endfunction : step_op

   function automatic logic is_kind(input ucsa_setup_s s, input logic rd);
      return s.req_type == (rd ? RT_VEND_IN : RT_VEND_OUT) &&
         s.request == (rd ? RQ_READ : RQ_LOAD) &&
         (s.value == SRC_CFG || s.value == SRC_EE);
   endfunction : is_kind

   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   ucsa_est_e e_st, next_e_st;
   ucsa_op_e e_op, next_e_op, go_op;
   logic [2:0] sync, next_sync;
   logic sda_f, next_sda_f;
   logic [1:0] ph, next_ph;
   logic [6:0] qcnt, next_qcnt;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh, go_byte;
   logic smp, next_smp;
   logic e_done, next_e_done;
   logic scl, next_scl;
   logic sda_low, next_sda_low;
   logic e_go;

   always_comb begin
      next_sync = {sync[1:0], sda_in};
      next_sda_f = (sync[1] == sync[2]) ? sync[2] : sda_f;
      next_e_st = e_st;
      next_e_op = e_op;
      next_ph = ph;
      next_qcnt = qcnt;
      next_bitn = bitn;
      next_sh = sh;
      next_smp = smp;
      next_e_done = 1'b0;
      unique case (e_st)
         E_IDLE: if (e_go) begin
            next_e_st = E_RUN;
            next_e_op = go_op;
            next_ph = 2'h0;
            next_qcnt = 7'h00;
            next_bitn = 4'h0;
            // start, stop and read keep the shifter so a read byte survives the stop
            if (go_op == OP_WR) begin
               next_sh = go_byte;
            end
         end
         E_RUN: if (qcnt == QTR_LAST) begin
            next_qcnt = 7'h00;
            next_ph = ph + 2'h1;
            if (ph == PH_SAMPLE) begin
               next_smp = sda_f;
            end
            if (ph == PH_LAST) begin
               if (e_op == OP_START || e_op == OP_STOP || bitn == BIT_ACK) begin
                  next_e_st = E_IDLE;
                  next_e_done = 1'b1;
               end else begin
                  next_bitn = bitn + 4'h1;
                  next_sh = {sh[6:0], smp};
               end
            end
         end else begin
            next_qcnt = qcnt + 7'h01;
         end
      endcase
      // line levels, data moves only while the clock is low, except at start and stop
      next_scl = scl;
      next_sda_low = sda_low;
      if (e_st == E_RUN) begin
         next_scl = (ph == 2'h1 || ph == PH_SAMPLE) || (e_op == OP_STOP && ph != 2'h0);
         unique case (e_op)
            OP_START: next_sda_low = ph[1];
            OP_STOP: next_sda_low = !ph[1];
            OP_WR: next_sda_low = (bitn != BIT_ACK) && !sh[7];
            OP_RD: next_sda_low = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         e_st <= E_IDLE;
         e_op <= OP_START;
         sync <= 3'h7;
         sda_f <= 1'b1;
         ph <= 2'h0;
         qcnt <= 7'h00;
         bitn <= 4'h0;
         sh <= 8'hFF;
         smp <= 1'b1;
         e_done <= 1'b0;
         scl <= 1'b1;
         sda_low <= 1'b0;
      end else begin
         e_st <= next_e_st;
         e_op <= next_e_op;
         sync <= next_sync;
         sda_f <= next_sda_f;
         ph <= next_ph;
         qcnt <= next_qcnt;
         bitn <= next_bitn;
         sh <= next_sh;
         smp <= next_smp;
         e_done <= next_e_done;
         scl <= next_scl;
         sda_low <= next_sda_low;
      end
   end

   // ----------------------------------------
   // request controller
   // ----------------------------------------
   ucsa_cst_e c_st, next_c_st;
   logic [2:0] step, next_step;
   logic rd_mode, next_rd_mode;
   logic to_ee, next_to_ee;
   logic boot, next_boot;
   logic armed, next_armed;
   logic [8:0] addr, next_addr;
   logic [15:0] remain, next_remain;
   logic [7:0] wbyte, next_wbyte;
   logic [7:0] rdat, next_rdat;
   logic [16:0] wc, next_wc;
   logic err, next_err;
   logic done, next_done;
   logic adv;
   ucsa_cfg_t cfg, next_cfg;
   ucsa_name_t name, next_name;

   assign e_go = (c_st == S_RUN) && armed && (e_st == E_IDLE);
   assign go_op = step_op(rd_mode, step);
   always_comb begin
      unique case (step)
         3'h1: go_byte = {EE_DEV_ID, EE_DEV_PINS, addr[8], 1'b0};
         3'h2: go_byte = addr[7:0];
         3'h3: go_byte = wbyte;
         3'h4: go_byte = {EE_DEV_ID, EE_DEV_PINS, addr[8], 1'b1};
         default: go_byte = 8'hFF;
      endcase
   end

   always_comb begin
      adv = 1'b0;
      next_c_st = c_st;
      next_step = step;
      next_rd_mode = rd_mode;
      next_to_ee = to_ee;
      next_boot = boot;
      next_armed = armed;
      next_addr = addr;
      next_remain = remain;
      next_wbyte = wbyte;
      next_rdat = rdat;
      next_wc = wc;
      next_err = 1'b0;
      next_done = 1'b0;
      next_cfg = cfg;
      next_name = name;
      unique case (c_st)
         S_IDLE: if (setup_valid_in) begin
            next_addr = {1'b0, setup_in.index[7:0]};
            next_remain = setup_in.length;
            next_to_ee = setup_in.value == SRC_EE;
            next_step = 3'h0;
            next_armed = 1'b1;
            if (is_kind(setup_in, 1'b0)) begin
               next_rd_mode = 1'b0;
               next_c_st = S_WGET;
            end else if (is_kind(setup_in, 1'b1)) begin
               next_rd_mode = 1'b1;
               next_c_st = (setup_in.value == SRC_EE) ? S_RUN : S_RSEND;
               next_rdat = cfg[setup_in.index[3:0]];
            end else begin
               next_err = 1'b1;
            end
            if (setup_in.length == 16'h0000 && next_c_st != S_IDLE) begin
               next_c_st = S_IDLE;
               next_done = 1'b1;
            end
         end
         S_WGET: if (wr_valid_in) begin
            next_wbyte = wr_data_in;
            if (to_ee) begin
               if (addr <= CFG_LAST) begin
                  next_cfg[addr[3:0]] = wr_data_in;
               end
               next_c_st = S_RUN;
               next_step = 3'h0;
               next_armed = 1'b1;
            end else begin
               next_cfg[addr[3:0]] = wr_data_in;
               adv = 1'b1;
            end
         end
         S_RUN: begin
            if (e_go) begin
               next_armed = 1'b0;
            end
            if (e_done) begin
               next_armed = 1'b1;
               next_step = step + 3'h1;
               if (step == (rd_mode ? STEP_RD_LAST : STEP_WR_LAST)) begin
                  next_step = 3'h0;
                  if (boot) begin
                     if (addr <= CFG_LAST) begin
                        next_cfg[addr[3:0]] = sh;
                     end else begin
                        next_name[5'(addr - NAME_FIRST)] = sh;
                     end
                     next_addr = (addr == CFG_LAST) ? NAME_FIRST : addr + 9'h001;
                     if (addr == NAME_LAST) begin
                        next_boot = 1'b0;
                        next_c_st = S_IDLE;
                     end
                  end else if (rd_mode) begin
                     next_rdat = sh;
                     next_c_st = S_RSEND;
                  end else begin
                     next_wc = 17'h00000;
                     next_c_st = S_WC;
                  end
               end
            end
         end
         S_WC: begin
            next_wc = wc + 17'h00001;
            if (wc == 17'(WC_CYCLES - 1)) begin
               next_c_st = S_WGET;
               adv = 1'b1;
            end
         end
         S_RSEND: if (rd_ready_in) begin
            adv = 1'b1;
            next_rdat = cfg[addr[3:0] + 4'h1];
            if (to_ee) begin
               next_c_st = S_RUN;
               next_step = 3'h0;
               next_armed = 1'b1;
            end
         end
      endcase
      if (adv) begin
         next_addr = {1'b0, addr[7:0] + 8'h01};
         next_remain = remain - 16'h0001;
         if (remain == 16'h0001) begin
            next_c_st = S_IDLE;
            next_done = 1'b1;
         end
      end
   end

   // reset starts the reload of the image from memory
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         c_st <= S_RUN;
         boot <= 1'b1;
         rd_mode <= 1'b1;
         armed <= 1'b1;
         step <= 3'h0;
         to_ee <= 1'b1;
         addr <= 9'h000;
         remain <= 16'h0000;
         wbyte <= 8'h00;
         rdat <= 8'h00;
         wc <= 17'h00000;
         err <= 1'b0;
         done <= 1'b0;
         cfg <= '0;
         name <= '0;
      end else begin
         c_st <= next_c_st;
         boot <= next_boot;
         rd_mode <= next_rd_mode;
         armed <= next_armed;
         step <= next_step;
         to_ee <= next_to_ee;
         addr <= next_addr;
         remain <= next_remain;
         wbyte <= next_wbyte;
         rdat <= next_rdat;
         wc <= next_wc;
         err <= next_err;
         done <= next_done;
         cfg <= next_cfg;
         name <= next_name;
      end
   end

   assign setup_ready_out = (c_st == S_IDLE);
   assign wr_ready_out = (c_st == S_WGET);
   assign rd_valid_out = (c_st == S_RSEND);
   assign rd_data_out = rdat;
   assign req_err_out = err;
   assign done_out = done;
   assign cfg_out = cfg;
   assign name_out = name;
   assign boot_done_out = !boot;
   assign scl_out = scl;
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_low;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [7:0] hi_cnt;
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hi_cnt <= 8'h00;
      end else begin
         hi_cnt <= scl ? hi_cnt + 8'h01 : 8'h00;
      end
   end

   a_bad_code_err: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      setup_valid_in && setup_ready_out && setup_in.req_type == RT_VEND_OUT &&
      setup_in.request != RQ_LOAD |=> req_err_out && setup_ready_out)
      else $error("unknown vendor code not flagged");
   a_load_decode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      setup_valid_in && setup_ready_out && is_kind(setup_in, 1'b0) &&
      setup_in.length != 16'h0000 |=> wr_ready_out && !rd_mode)
      else $error("load request not taken as write");
   a_read_decode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      setup_valid_in && setup_ready_out && is_kind(setup_in, 1'b1) &&
      setup_in.value == SRC_EE && setup_in.length != 16'h0000 |=> c_st == S_RUN && rd_mode)
      else $error("memory read not started");
   a_local_write_only: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      wr_ready_out && !to_ee |-> e_st == E_IDLE ##1 e_st == E_IDLE)
      else $error("internal write touched serial memory");
   a_mirror_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      wr_ready_out && wr_valid_in && to_ee && addr <= CFG_LAST |=>
      cfg[$past(addr[3:0])] == $past(wr_data_in))
      else $error("memory write not mirrored");
   a_read_cfg_src: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      rd_valid_out && !to_ee |-> rd_data_out == cfg[addr[3:0]])
      else $error("internal read returned wrong byte");
   a_scl_high_time: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      $fell(scl) && e_op != OP_START |-> $past(hi_cnt) == 8'(2 * QTR_LAST + 1))
      else $error("clock high time off");
   a_sda_stable_hi: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      scl && $past(scl) && (e_op == OP_WR || e_op == OP_RD) |-> $stable(sda_low))
      else $error("data moved while clock high");
   a_boot_blocks: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      boot |-> !setup_ready_out)
      else $error("request taken before image load");
   a_name_jump: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      boot && addr == CFG_LAST && e_done && step == STEP_RD_LAST |=> addr == NAME_FIRST)
      else $error("name load not at its offset");
   a_host_addr_8bit: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      !boot && c_st == S_RUN |-> !addr[8])
      else $error("host access beyond 256 bytes");
endmodule : ucsa_top

// file: design/ucsa_pkg.sv
package ucsa_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int QTR_NS = 2500;
   localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
   localparam logic [6:0] QTR_M1 = 7'(QTR_CYC - 1);
   localparam int WC_NS = 5000000;
   localparam int WC_CYC = (WC_NS / 1000) * CLK_MHZ;
   // ----------------------------------------
   // request codes
   // ----------------------------------------
   localparam logic [7:0] RT_VEND_OUT = 8'h40;
   localparam logic [7:0] RT_VEND_IN = 8'hC0;
   localparam logic [7:0] RQ_LOAD = 8'h01;
   localparam logic [7:0] RQ_READ = 8'h02;
   localparam logic [15:0] SRC_CFG = 16'h0000;
   localparam logic [15:0] SRC_EE = 16'h0002;
   // ----------------------------------------
   // memory map
   // ----------------------------------------
   localparam int CFG_BYTES = 16;
   localparam int NAME_BYTES = 24;
   localparam logic [8:0] CFG_LAST = 9'h00F;
   localparam logic [8:0] NAME_FIRST = 9'h104;
   localparam logic [8:0] NAME_LAST = 9'h11B;
   localparam logic [3:0] EE_DEV_ID = 4'hA;
   localparam logic [1:0] EE_DEV_PINS = 2'h0;
   // ----------------------------------------
   // serial sequencing
   // ----------------------------------------
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_LAST = 2'h3;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [2:0] STEP_WR_LAST = 3'h4;
   localparam logic [2:0] STEP_RD_LAST = 3'h6;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] req_type;
      logic [7:0] request;
      logic [15:0] value;
      logic [15:0] index;
      logic [15:0] length;
   } ucsa_setup_s;
   typedef logic [CFG_BYTES-1:0][7:0] ucsa_cfg_t;
   typedef logic [NAME_BYTES-1:0][7:0] ucsa_name_t;
   typedef enum {OP_START, OP_WR, OP_RD, OP_STOP} ucsa_op_e;
   typedef enum {E_IDLE, E_RUN} ucsa_est_e;
   typedef enum {S_IDLE, S_WGET, S_RUN, S_WC, S_RSEND} ucsa_cst_e;
endpackage : ucsa_pkg

// file: verification/ucsa_ee_model.sv
`timescale 1ns/10ps
module ucsa_ee_model (
   // serial memory pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_pull_out
);
   logic [7:0] mem [0:511];
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'hFF;
   logic [8:0] addr = 9'h000;
   logic [3:0] bitn = 4'h0;
   logic [1:0] nbyte = 2'h0;
   logic active = 1'b0;
   logic rd_mode = 1'b0;
   initial begin
      sda_pull_out = 1'b0;
      for (int i = 0; i < 512; i++) begin
         mem[i] = (i < 256) ? 8'(i * 7 + 3) : 8'hFF;
      end
      for (int j = 0; j < 24; j++) begin
         mem[260 + j] = 8'(8'h41 + j);
      end
   end
   // ----------------------------------------
   // framing: data edges while the clock is high
   // ----------------------------------------
   always @(negedge sda_in) begin
      if (scl_in === 1'b1) begin
         active = 1'b1;
         // the clock fall that closes the start must not count as a bit
         bitn = 4'hF;
         nbyte = 2'h0;
         rd_mode = 1'b0;
      end
   end
   always @(posedge sda_in) begin
      if (scl_in === 1'b1) begin
         active = 1'b0;
      end
   end
   // ----------------------------------------
   // bit transfer
   // ----------------------------------------
   always @(posedge scl_in) begin
      if (active && !rd_mode && bitn < 4'h8) begin
         sh = {sh[6:0], sda_in};
      end
      if (active && rd_mode && bitn == 4'h8 && sda_in) begin
         active = 1'b0;
      end
   end
   always @(negedge scl_in) begin
      if (active && bitn == 4'h8) begin
         bitn = 4'h0;
         sda_pull_out = rd_mode & ~tx[7];
      end else if (active) begin
         bitn = bitn + 4'h1;
         sda_pull_out = rd_mode & (bitn < 4'h8) & ~tx[3'(4'h7 - bitn)];
         if (!rd_mode && bitn == 4'h8) begin
            sda_pull_out = 1'b1;
            if (nbyte == 2'h0) begin
               sda_pull_out = (sh[7:2] == 6'h28);
               addr[8] = sh[1];
               rd_mode = sh[0];
               tx = mem[addr];
            end else if (nbyte == 2'h1) begin
               addr[7:0] = sh;
            end else begin
               mem[addr] = sh;
               addr[7:0] = addr[7:0] + 8'h01;
            end
            nbyte = (nbyte == 2'h3) ? nbyte : nbyte + 2'h1;
         end
      end
   end
endmodule : ucsa_ee_model

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench import ucsa_pkg::*;;
   localparam int TICK = 40;
   localparam int LIMIT = 80000;
   localparam int QTR = 3;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic setup_valid = 1'b0;
   ucsa_setup_s setup = '0;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic rd_ready = 1'b0;
   logic setup_ready, req_err, done, wr_ready, rd_valid, boot_done;
   logic scl, sda_drv, sda_oe, ee_pull, sda_line;
   logic [7:0] rd_data;
   ucsa_cfg_t cfg;
   ucsa_name_t name;
   logic [7:0] cfg_exp [16];
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   time t_rise = 0;
   time scl_hi = 0;
   // data line has a pull-up; either party may pull it low
   assign sda_line = ~(sda_oe | ee_pull);
   always #(TICK / 2) clk = ~clk;
   always @(posedge scl) t_rise = $time;
   always @(negedge scl) scl_hi = $time - t_rise;
   ucsa_top #(.WC_CYCLES(20), .QTR_LAST(7'(QTR))) i_ucsa_top (.ref_clk_in(clk), .resetn_in(resetn),
      .setup_valid_in(setup_valid), .setup_in(setup), .setup_ready_out(setup_ready),
      .req_err_out(req_err), .done_out(done), .wr_valid_in(wr_valid), .wr_data_in(wr_data),
      .wr_ready_out(wr_ready), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
      .rd_ready_in(rd_ready), .cfg_out(cfg), .name_out(name), .boot_done_out(boot_done),
      .scl_out(scl), .sda_in(sda_line), .sda_out(sda_drv), .sda_oe_out(sda_oe));
   ucsa_ee_model i_ucsa_ee_model (.scl_in(scl), .sda_in(sda_line), .sda_pull_out(ee_pull));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         final_report();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic await(input int which);
      logic hit;
      hit = 1'b0;
      for (int n = 0; !hit; n++) begin
         @(negedge clk);
         case (which)
            0: hit = (setup_ready === 1'b1);
            1: hit = (wr_ready === 1'b1);
            2: hit = (rd_valid === 1'b1);
            default: hit = (done === 1'b1) || (req_err === 1'b1);
         endcase
         if (!hit && n > 30000) begin
            check(0, 1, "handshake wait ran out");
            hit = 1'b1;
         end
      end
   endtask : await
   task automatic cmp_cfg;
      for (int i = 0; i < 16; i++) begin
         check(cfg[i], cfg_exp[i], "config byte");
      end
   endtask : cmp_cfg
   task automatic request(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] vl,
         input logic [7:0] idx, input logic [15:0] len);
      setup <= '{rt, rq, vl, {8'h00, idx}, len};
      setup_valid <= 1'b1;
      await(0);
      @(posedge clk);
      setup_valid <= 1'b0;
   endtask : request
   task automatic do_write(input logic [15:0] vl, input logic [7:0] idx, input int n,
         input logic [7:0] d0);
      request(RT_VEND_OUT, RQ_LOAD, vl, idx, 16'(n));
      for (int k = 0; k < n; k++) begin
         wr_valid <= 1'b1;
         wr_data <= d0 + 8'(k);
         await(1);
         @(posedge clk);
      end
      wr_valid <= 1'b0;
      await(3);
      check(done, 1'b1, "write finished");
      @(posedge clk);
   endtask : do_write
   task automatic do_read(input logic [15:0] vl, input logic [7:0] idx, input int n);
      logic [7:0] exp;
      request(RT_VEND_IN, RQ_READ, vl, idx, 16'(n));
      for (int k = 0; k < n; k++) begin
         await(2);
         @(posedge clk);
         rd_ready <= 1'b1;
         await(2);
         exp = i_ucsa_ee_model.mem[8'(idx + k)];
         if (vl == SRC_CFG) begin
            exp = cfg_exp[4'(idx + k)];
         end
         check(rd_data, exp, "read byte");
         @(posedge clk);
         rd_ready <= 1'b0;
      end
      await(3);
      check(done, 1'b1, "read finished");
      @(posedge clk);
   endtask : do_read
   task automatic do_reset;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (6) @(posedge clk);
      check(32'(|cfg), 0, "config cleared");
      check(scl, 1'b1, "clock idle");
      check(sda_oe, 1'b0, "data released");
      check(sda_drv, 1'b0, "data drive level");
      resetn <= 1'b1;
      @(negedge clk);
      check(setup_ready, 1'b0, "no request during load");
   endtask : do_reset
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_boot;
      for (int i = 0; i < 40000 && setup_ready !== 1'b1; i++) @(negedge clk);
      check(boot_done, 1'b1, "load finished first");
      for (int i = 0; i < 16; i++) cfg_exp[i] = i_ucsa_ee_model.mem[i];
      cmp_cfg();
      for (int j = 0; j < 24; j++) begin
         check(name[j], i_ucsa_ee_model.mem[260 + j], "name byte");
      end
      @(posedge clk);
      $display("test boot done");
   endtask : t_boot
   task automatic t_internal;
      time tr;
      logic [7:0] m;
      tr = t_rise;
      m = i_ucsa_ee_model.mem[14];
      do_write(SRC_CFG, 8'h0E, 2, 8'h9C);
      do_write(SRC_CFG, 8'h02, 1, 8'h11);
      cfg_exp[14] = 8'h9C;
      cfg_exp[15] = 8'h9D;
      cfg_exp[2] = 8'h11;
      cmp_cfg();
      check(i_ucsa_ee_model.mem[14], m, "memory kept");
      check(t_rise, tr, "no serial traffic");
      do_read(SRC_CFG, 8'h00, 16);
      $display("test internal done");
   endtask : t_internal
   task automatic t_memory;
      do_write(SRC_EE, 8'h05, 1, 8'h5A);
      check(i_ucsa_ee_model.mem[5], 8'h5A, "memory byte");
      check(32'(scl_hi), 2 * (QTR + 1) * TICK, "clock high time");
      do_write(SRC_EE, 8'hFF, 2, 8'hC1);
      check(i_ucsa_ee_model.mem[255], 8'hC1, "top byte");
      check(i_ucsa_ee_model.mem[0], 8'hC2, "wrapped byte");
      check(i_ucsa_ee_model.mem[256], 8'hFF, "upper block kept");
      cfg_exp[5] = 8'h5A;
      cfg_exp[0] = 8'hC2;
      cmp_cfg();
      do_read(SRC_EE, 8'hFE, 2);
      $display("test memory done");
   endtask : t_memory
   task automatic t_refuse;
      logic [7:0] rt [6] = '{8'h40, 8'hC0, 8'h40, 8'hC0, 8'hC0, 8'h40};
      logic [7:0] rq [6] = '{8'h03, 8'h05, 8'h01, 8'h02, 8'h01, 8'h01};
      logic [15:0] vl [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0003, 16'h0000, 16'h0000};
      logic ex [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         request(rt[i], rq[i], vl[i], 8'h05, {15'h0000, ex[i]});
         await(3);
         check(req_err, ex[i], "request error");
         check(done, !ex[i], "request done");
         @(posedge clk);
      end
      cmp_cfg();
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_reload;
      i_ucsa_ee_model.mem[3] = 8'h3C;
      do_reset();
      t_boot();
      $display("test reload done");
   endtask : t_reload
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   initial begin
      do_reset();
      t_boot();
      t_internal();
      t_refuse();
      t_memory();
      t_reload();
      final_report();
   end
endmodule : testbench
